// ==== include/spcd_pkg.sv ====
// Package of constants and types for the status pin clock dividers.
package spcd_pkg;

	// ==========================================================
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] SPCD_IDX_CTRL = 8'h2d; // Pre-divider and pin source selection.
	localparam logic [7:0] SPCD_IDX_DIV_A = 8'h2e; // Divider A code.
	localparam logic [7:0] SPCD_IDX_DIV_B = 8'h2f; // Divider B code.
	localparam logic [7:0] SPCD_IDX_EDGE = 8'h31; // Pin edge-rate selection.
	localparam logic [7:0] SPCD_IDX_STAT = 8'h32; // Read-only live state.
	localparam int SPCD_ADDR_W = 12; // Width of the APB address.

	// ==========================================================
	// Reset values.
	localparam logic [7:0] SPCD_CTRL_RST = 8'h0a; // Both selectors at normal status.
	localparam logic [7:0] SPCD_DIV_RST = 8'h00; // Dividers disabled.
	localparam logic [3:0] SPCD_EDGE_RST = 4'h0; // Fast edges.

	// ==========================================================
	// Field positions inside the control and edge-rate registers.
	localparam int SPCD_SEL_A_LSB = 0; // Pin A source selector.
	localparam int SPCD_SEL_B_LSB = 2; // Pin B source selector.
	localparam int SPCD_PRE_A_LSB = 4; // Synth A pre-divider code.
	localparam int SPCD_PRE_B_LSB = 6; // Synth B pre-divider code.
	localparam int SPCD_EDGE_A_LSB = 0; // Pin A edge rate.
	localparam int SPCD_EDGE_B_LSB = 2; // Pin B edge rate.

	// ==========================================================
	// Encodings.
	localparam logic [1:0] SPCD_SEL_DIV_A = 2'h0; // Pin driven by divider A.
	localparam logic [1:0] SPCD_SEL_DIV_B = 2'h1; // Pin driven by divider B.
	localparam logic [1:0] SPCD_SEL_STATUS = 2'h2; // Normal status signalling.
	localparam logic [1:0] SPCD_SEL_OFF = 2'h3; // Pin disabled.
	localparam logic [1:0] SPCD_EDGE_SLOW = 2'h2; // Slow edge; fast is zero.
	localparam logic [1:0] SPCD_PRE_OFF = 2'h0; // Pre-divider disabled.
	localparam logic [1:0] SPCD_PRE_BY4 = 2'h1; // Pre-divider divides by 4.
	localparam logic [1:0] SPCD_PRE_BY5 = 2'h2; // Pre-divider divides by 5.
	localparam logic [2:0] SPCD_PRE_LAST4 = 3'h3; // Last count when dividing by 4.
	localparam logic [2:0] SPCD_PRE_LAST5 = 3'h4; // Last count when dividing by 5.
	localparam logic [7:0] SPCD_DIV_OFF = 8'h00; // Divider code meaning disabled.
	localparam logic [7:0] SPCD_DIV_MIN = 8'h06; // Smallest code that is taken as is.
	localparam logic [7:0] SPCD_DIV_LAST_MIN = 8'h05; // Last count for a ratio of 6.

	// ==========================================================
	// One status pin as driven to the pad.
	typedef struct packed {
		logic out; // Pin level.
		logic oe; // High while the pin is driven.
		logic slow; // High selects the slow edge.
	} spcd_pin_t;

	// Last count of a divider cycle: ratio minus one.
	function automatic logic [7:0] spcd_last(input logic [7:0] code);
		spcd_last = (code < SPCD_DIV_MIN) ? SPCD_DIV_LAST_MIN : code;
	endfunction

endpackage

// ==== core/spcd_divider.sv ====
// One pre-divider followed by one 8-bit auxiliary divider.
module spcd_divider
	import spcd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] prediv_code,
	input wire logic [7:0] div_code,
	output logic clk_out,
	output logic running
);

	// ==========================================================
	// State.
	logic [2:0] pre_q, pre_d; // Pre-divider count.
	logic [7:0] cnt_q, cnt_d; // Auxiliary divider count.
	logic out_q, out_d; // Divided clock.
	logic [2:0] pre_last; // Last pre-divider count.
	logic [7:0] last; // Last auxiliary count.
	logic [8:0] half; // Counts below this drive the output high.
	logic tick; // One pulse per pre-divided period.

	// Reserved pre-divider codes are treated as disabled, so no odd ratio leaks out.
	always_comb begin
		running = ((prediv_code == SPCD_PRE_BY4) || (prediv_code == SPCD_PRE_BY5))
			&& (div_code != SPCD_DIV_OFF); // [RULE8] [RULE9]
		pre_last = (prediv_code == SPCD_PRE_BY4) ? SPCD_PRE_LAST4 : SPCD_PRE_LAST5; // [RULE8]
		last = spcd_last(div_code); // [RULE2] [RULE4]
		half = ({1'b0, last} + 9'h001) >> 1;
		tick = running && (pre_q >= pre_last);
	end

	// Next state; a stopped divider clears and parks low, a running one only moves its count and output on a tick.
	always_comb begin
		pre_d = pre_q;
		cnt_d = cnt_q;
		out_d = out_q;
		if (!running) begin
			pre_d = 3'h0; // [RULE9]
			cnt_d = 8'h00;
			out_d = 1'b0;
		end else if (tick) begin
			pre_d = 3'h0;
			// Wrapping on greater-or-equal keeps a shortened code from running past its end.
			cnt_d = (cnt_q >= last) ? 8'h00 : cnt_q + 8'h01; // [RULE1] [RULE3]
			out_d = ({1'b0, cnt_d} < half);
		end else begin
			pre_d = pre_q + 3'h1;
		end
	end

	// Registers only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 3'h0;
			cnt_q <= 8'h00;
			out_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign clk_out = out_q;

	// ==========================================================
	// Checks.
	stop_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		!running |=> !clk_out && (cnt_q == 8'h00))
		else $error("stopped divider moved");
	ratio_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
		(tick && (cnt_q >= last) && $stable(div_code)) |=> (cnt_q == 8'h00))
		else $error("divider did not wrap at its ratio");
	// A small code must step through every count below five, so it can never wrap early.
	ratio_floor_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
		(tick && (div_code != SPCD_DIV_OFF) && (div_code < SPCD_DIV_MIN)
		&& (cnt_q < SPCD_DIV_LAST_MIN) && $stable(div_code))
		|=> (cnt_q == $past(cnt_q) + 8'h01))
		else $error("divide ratio below six");
	pre_span_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
		(running && (prediv_code == SPCD_PRE_BY4) && (pre_q == 3'h0)) ##1
		(running && (prediv_code == SPCD_PRE_BY4))[*3] |-> tick)
		else $error("pre-divide by four missed its tick");

endmodule

// ==== core/spcd_top.sv ====
// Status pin clock dividers with their APB register file and pin selection.
//
// Summary of operation
// [RULE1] Divider A: 8-bit, from synth A, reset zero.
// [RULE2] Code 0 off, 1-5 give 6, else code+1.
// [RULE3] Divider B: 8-bit, from synth B, reset zero.
// [RULE4] Divider B uses the same code encoding.
// [RULE5] Pin B edge rate: 0 fast, 2 slow.
// [RULE6] Pin A edge rate: 0 fast, 2 slow.
// [RULE7] Pin source: A, B, status, off; reset status.
// [RULE8] Pre-divider: 0 off, 1 by 4, 2 by 5.
// [RULE9] Stopped divider holds its output quietly low.
//
// The implementer's own choice: the APB slave port.
module spcd_top
	import spcd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SPCD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic status_a_level,
	input wire logic status_b_level,
	output spcd_pin_t monitor_pin_a,
	output spcd_pin_t monitor_pin_b
);

	// ==========================================================
	// Address decode.

	// Byte address of a register index.
	function automatic logic [SPCD_ADDR_W-1:0] spcd_addr(input logic [7:0] idx);
		spcd_addr = {{(SPCD_ADDR_W-10){1'b0}}, idx, 2'b00};
	endfunction

	logic hit_ctrl, hit_div_a, hit_div_b, hit_edge, hit_stat; // One per register.
	logic mapped; // Address names a register.
	logic setup; // First cycle of a transfer.
	logic wr_en; // Write takes effect this edge.

	// The slave answers every access phase at once, so the access edge is the write edge.
	always_comb begin
		hit_ctrl = (paddr == spcd_addr(SPCD_IDX_CTRL));
		hit_div_a = (paddr == spcd_addr(SPCD_IDX_DIV_A));
		hit_div_b = (paddr == spcd_addr(SPCD_IDX_DIV_B));
		hit_edge = (paddr == spcd_addr(SPCD_IDX_EDGE));
		hit_stat = (paddr == spcd_addr(SPCD_IDX_STAT));
		mapped = hit_ctrl | hit_div_a | hit_div_b | hit_edge | hit_stat;
		setup = psel && !penable;
		wr_en = psel && penable && pwrite;
	end

	// ==========================================================
	// Configuration registers.
	logic [7:0] ctrl_q, ctrl_d; // Pre-divider codes and pin source selectors.
	logic [7:0] div_a_q, div_a_d; // Divider A code.
	logic [7:0] div_b_q, div_b_d; // Divider B code.
	logic [3:0] edge_q, edge_d; // Two edge-rate fields; the upper nibble is reserved.

	// Next values from bus writes; the status register ignores writes.
	always_comb begin
		ctrl_d = ctrl_q;
		div_a_d = div_a_q;
		div_b_d = div_b_q;
		edge_d = edge_q;
		if (wr_en && hit_ctrl) begin
			ctrl_d = pwdata[7:0]; // [RULE7] [RULE8]
		end
		if (wr_en && hit_div_a) begin
			div_a_d = pwdata[7:0]; // [RULE1]
		end
		if (wr_en && hit_div_b) begin
			div_b_d = pwdata[7:0]; // [RULE3]
		end
		if (wr_en && hit_edge) begin
			edge_d = pwdata[3:0]; // [RULE5] [RULE6]
		end
	end

	// Registers only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= SPCD_CTRL_RST; // [RULE7] [RULE8]
			div_a_q <= SPCD_DIV_RST; // [RULE1]
			div_b_q <= SPCD_DIV_RST; // [RULE3]
			edge_q <= SPCD_EDGE_RST; // [RULE5] [RULE6]
		end else begin
			ctrl_q <= ctrl_d;
			div_a_q <= div_a_d;
			div_b_q <= div_b_d;
			edge_q <= edge_d;
		end
	end

	// Field views.
	logic [1:0] sel_a, sel_b, pre_a, pre_b, rate_a, rate_b;
	assign sel_a = ctrl_q[SPCD_SEL_A_LSB +: 2];
	assign sel_b = ctrl_q[SPCD_SEL_B_LSB +: 2];
	assign pre_a = ctrl_q[SPCD_PRE_A_LSB +: 2];
	assign pre_b = ctrl_q[SPCD_PRE_B_LSB +: 2];
	assign rate_a = edge_q[SPCD_EDGE_A_LSB +: 2];
	assign rate_b = edge_q[SPCD_EDGE_B_LSB +: 2];

	// ==========================================================
	// Dividers.
	logic clk_a, clk_b; // Divided clocks.
	logic run_a, run_b; // Divider is producing edges.

	// Divider A follows synth A's pre-divider.
	spcd_divider u_div_a (
		.pclk(pclk),
		.presetn(presetn),
		.prediv_code(pre_a),
		.div_code(div_a_q),
		.clk_out(clk_a),
		.running(run_a)
	); // [RULE1]

	// Divider B follows synth B's pre-divider.
	spcd_divider u_div_b (
		.pclk(pclk),
		.presetn(presetn),
		.prediv_code(pre_b),
		.div_code(div_b_q),
		.clk_out(clk_b),
		.running(run_b)
	); // [RULE3]

	// ==========================================================
	// Pin selection.
	spcd_pin_t pin_a_q, pin_a_d, pin_b_q, pin_b_d; // Registered pin drive.

	// One pin's drive from its selector and edge-rate code.
	function automatic spcd_pin_t spcd_pin(input logic [1:0] sel, input logic [1:0] rate,
		input logic ca, input logic cb, input logic st);
		spcd_pin.oe = (sel != SPCD_SEL_OFF);
		spcd_pin.slow = (rate == SPCD_EDGE_SLOW);
		unique case (sel)
			SPCD_SEL_DIV_A: spcd_pin.out = ca;
			SPCD_SEL_DIV_B: spcd_pin.out = cb;
			SPCD_SEL_STATUS: spcd_pin.out = st;
			SPCD_SEL_OFF: spcd_pin.out = 1'b0;
		endcase
	endfunction

	// Reserved edge codes fall back to the fast edge, the safer default for a clock.
	always_comb begin
		pin_a_d = spcd_pin(sel_a, rate_a, clk_a, clk_b, status_a_level); // [RULE6] [RULE7]
		pin_b_d = spcd_pin(sel_b, rate_b, clk_a, clk_b, status_b_level); // [RULE5] [RULE7]
	end

	// Registers only; the pins come from flip-flops and cannot glitch on a selector change.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_a_q <= '0;
			pin_b_q <= '0;
		end else begin
			pin_a_q <= pin_a_d;
			pin_b_q <= pin_b_d;
		end
	end

	assign monitor_pin_a = pin_a_q;
	assign monitor_pin_b = pin_b_q;

	// ==========================================================
	// Read data and answer.
	logic [31:0] rdata_q, rdata_d; // Read data captured in the setup cycle.
	logic err_q, err_d; // Unmapped address seen in the setup cycle.

	// Read data is latched at setup so that it stands through the access phase.
	always_comb begin
		rdata_d = rdata_q;
		err_d = err_q;
		if (setup) begin
			rdata_d = 32'h0000_0000;
			err_d = !mapped;
			if (hit_ctrl) begin
				rdata_d[7:0] = ctrl_q;
			end
			if (hit_div_a) begin
				rdata_d[7:0] = div_a_q;
			end
			if (hit_div_b) begin
				rdata_d[7:0] = div_b_q;
			end
			if (hit_edge) begin
				rdata_d[3:0] = edge_q;
			end
			if (hit_stat) begin
				rdata_d[3:0] = {run_b, run_a, clk_b, clk_a};
			end
		end
	end

	// Registers only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// Zero wait states: every access phase ends at its first edge.
	assign prdata = rdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && err_q;

	// ==========================================================
	// Checks.
	div_a_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		(wr_en && hit_div_a) |=> (div_a_q == $past(pwdata[7:0])))
		else $error("divider A code not stored");
	div_b_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
		(wr_en && hit_div_b) |=> (div_b_q == $past(pwdata[7:0])))
		else $error("divider B code not stored");
	pin_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
		(sel_a == SPCD_SEL_OFF) ##1 (sel_a == SPCD_SEL_OFF) |-> !monitor_pin_a.oe
		&& !monitor_pin_a.out)
		else $error("disabled pin still driven");
	pin_route_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
		(sel_b == SPCD_SEL_DIV_A) |=> (monitor_pin_b.out == $past(clk_a)) && monitor_pin_b.oe)
		else $error("pin B does not follow divider A");
	slow_b_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
		(rate_b == SPCD_EDGE_SLOW) |=> monitor_pin_b.slow)
		else $error("pin B slow edge not selected");
	fast_a_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
		(rate_a != SPCD_EDGE_SLOW) |=> !monitor_pin_a.slow)
		else $error("pin A not on fast edge");
	idle_div_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		((div_a_q == SPCD_DIV_OFF) || (pre_a == SPCD_PRE_OFF))[*2] |-> !clk_a && !run_a)
		else $error("disabled divider A toggles");
	edge_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
		(setup && hit_edge) |=> (prdata[31:4] == 28'h0000000))
		else $error("reserved edge-rate bits read nonzero");

endmodule

// ==== tb/spcd_testbench.sv ====
// Self-checking testbench for the status pin clock dividers.
module testbench
	import spcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals facing the block.
	logic pclk, presetn, psel, penable, pwrite; // Clock, reset and APB controls.
	logic [SPCD_ADDR_W-1:0] paddr; // Byte address.
	logic [31:0] pwdata, prdata; // APB data.
	logic pready, pslverr; // APB answer.
	logic status_a_level, status_b_level; // Normal status levels.
	spcd_pin_t monitor_pin_a, monitor_pin_b; // Pin outputs.
	int errors, checks; // Mismatch and comparison counts.
	logic [31:0] rdat; // Data of the last transfer.
	logic rerr; // Error of the last transfer.
	int codes[5] = '{1, 5, 6, 7, 255}; // Divider codes around both boundaries.
	int r; // Expected divide ratio.

	spcd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .status_a_level(status_a_level), .status_b_level(status_b_level),
		.monitor_pin_a(monitor_pin_a), .monitor_pin_b(monitor_pin_b));

	// ==========================================================
	// Clock at 100 MHz.
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	// Prints the verdict and ends the run; the only exit point.
	task automatic stop_test();
		if (errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Compares one value and reports a difference at once.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; it first lets an edge pass so psel is never assigned twice at once.
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		// A slave that never answers ends the run.
		if (pready !== 1'h1) begin
			errors++;
			stop_test();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Level of the chosen pin.
	function automatic logic pin_out(input logic use_b);
		pin_out = use_b ? monitor_pin_b.out : monitor_pin_a.out;
	endfunction

	// Counts samples up to and including the next rising edge of a pin, and its high samples.
	task automatic count(input logic use_b, output int p, output int h);
		logic prev, cur;
		p = 0;
		h = 0;
		cur = pin_out(use_b);
		do begin
			prev = cur;
			@(negedge pclk);
			cur = pin_out(use_b);
			p++;
			if (cur === 1'h1) h++;
		end while (!(prev === 1'h0 && cur === 1'h1) && p < 3000);
		if (p >= 3000) begin
			errors++;
			stop_test();
		end
	endtask

	// Skips up to the first rising edge and one whole period after it, then measures the next whole one.
	task automatic measure(input logic use_b, input int per, input int high);
		int p, h;
		count(use_b, p, h);
		count(use_b, p, h);
		count(use_b, p, h);
		check(use_b ? "pin b period" : "pin a period", p, per);
		check(use_b ? "pin b high" : "pin a high", h, high);
	endtask

	// A stopped divider must leave its pin low with no stray edge.
	task automatic quiet(input logic use_b);
		int bad;
		bad = 0;
		repeat (8) @(negedge pclk);
		repeat (300) begin
			@(negedge pclk);
			if (pin_out(use_b) !== 1'h0) bad++;
		end
		check("stopped pin", bad, 0);
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		errors = 0;
		checks = 0;
		presetn = 1'h0;
		{psel, penable, pwrite} = 3'h0;
		paddr = '0;
		pwdata = 32'h0;
		status_a_level = 1'h1;
		status_b_level = 1'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		// Reset state: pins follow status with fast edges, registers at reset.
		repeat (3) @(negedge pclk);
		check("pin a reset", {29'h0, monitor_pin_a}, 32'h6);
		check("pin b reset", {29'h0, monitor_pin_b}, 32'h2);
		apb(1'h0, SPCD_IDX_CTRL, 32'h0);
		check("ctrl reset", rdat, 32'h0a);
		apb(1'h0, SPCD_IDX_DIV_A, 32'h0);
		check("div a reset", rdat, 32'h0);
		apb(1'h0, SPCD_IDX_DIV_B, 32'h0);
		check("div b reset", rdat, 32'h0);
		apb(1'h0, SPCD_IDX_EDGE, 32'h0);
		check("edge reset", rdat, 32'h0);
		// An unmapped place is refused both ways.
		apb(1'h1, 8'h30, 32'hffff_ffff);
		check("unmapped write err", {31'h0, rerr}, 32'h1);
		apb(1'h0, 8'h30, 32'h0);
		check("unmapped read err", {31'h0, rerr}, 32'h1);
		check("unmapped read data", rdat, 32'h0);
		// Dividers are 8 bits wide; upper write bits are dropped.
		apb(1'h1, SPCD_IDX_DIV_A, 32'h1234_565a);
		apb(1'h0, SPCD_IDX_DIV_A, 32'h0);
		check("div a rw", rdat, 32'h5a);
		apb(1'h1, SPCD_IDX_DIV_B, 32'h8765_43a5);
		apb(1'h0, SPCD_IDX_DIV_B, 32'h0);
		check("div b rw", rdat, 32'ha5);
		// Every edge code on both pins, with reserved bits set in the write.
		for (int c = 0; c < 4; c++) begin
			apb(1'h1, SPCD_IDX_EDGE, 32'hf0 | ((3 - c) << 2) | c);
			apb(1'h0, SPCD_IDX_EDGE, 32'h0);
			check("edge rw", rdat, ((3 - c) << 2) | c);
			repeat (3) @(negedge pclk);
			check("pin a slow", monitor_pin_a.slow, c == 2);
			check("pin b slow", monitor_pin_b.slow, c == 1);
		end
		apb(1'h1, SPCD_IDX_EDGE, 32'h0);
		// Status levels pass through, then both pins are switched off.
		status_a_level <= 1'h0;
		status_b_level <= 1'h1;
		repeat (3) @(negedge pclk);
		check("pin a status", {29'h0, monitor_pin_a}, 32'h2);
		check("pin b status", {29'h0, monitor_pin_b}, 32'h6);
		apb(1'h1, SPCD_IDX_CTRL, 32'h0f);
		repeat (3) @(negedge pclk);
		check("pin a off", {29'h0, monitor_pin_a}, 32'h0);
		check("pin b off", {29'h0, monitor_pin_b}, 32'h0);
		// Pin A on divider A by 4, pin B on divider B by 5, over the code boundaries.
		apb(1'h1, SPCD_IDX_CTRL, 32'h94);
		foreach (codes[i]) begin
			apb(1'h1, SPCD_IDX_DIV_A, codes[i]);
			apb(1'h1, SPCD_IDX_DIV_B, codes[i]);
			r = (codes[i] < 6) ? 6 : codes[i] + 1;
			// The output stays high for the lower half of the ratio, rounded down.
			measure(1'h0, 4 * r, 4 * (r / 2));
			measure(1'h1, 5 * r, 5 * (r / 2));
		end
		apb(1'h0, SPCD_IDX_STAT, 32'h0);
		check("both running", rdat & 32'hc, 32'hc);
		// Crossed selection: each pin shows the other divider.
		apb(1'h1, SPCD_IDX_CTRL, 32'h91);
		measure(1'h0, 5 * 256, 5 * 128);
		measure(1'h1, 4 * 256, 4 * 128);
		// Stopping by code zero and by a disabled or reserved pre-divider.
		apb(1'h1, SPCD_IDX_CTRL, 32'h94);
		apb(1'h1, SPCD_IDX_DIV_A, 32'h0);
		quiet(1'h0);
		apb(1'h1, SPCD_IDX_DIV_B, 32'h0);
		quiet(1'h1);
		apb(1'h1, SPCD_IDX_DIV_A, 32'h6);
		apb(1'h1, SPCD_IDX_CTRL, 32'h84);
		quiet(1'h0);
		apb(1'h1, SPCD_IDX_CTRL, 32'hb4);
		quiet(1'h0);
		stop_test();
	end

endmodule
